// ==== common/port1_mux_pkg.sv ====
/*
 * Shared constants and carriers for the low-nibble pin function mux.
 * Assumes a 32-bit APB slave on a 12-bit byte address.
 */
package port1_mux_pkg;

    // ==========================================================
    // Register map
    localparam int ADDR_W = 12;
    localparam logic [11:0] PORT_CTRL_OFF = 12'h000;
    localparam logic [11:0] TMR0_CFG_OFF = 12'h004;
    localparam logic [11:0] PRESCALE_OFF = 12'h008;
    localparam logic [11:0] STATUS_OFF = 12'h00C;
    localparam logic [31:0] PORT_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] TMR0_CFG_RST = 32'h0000_0000;
    localparam logic [31:0] PRESCALE_RST = 32'h0000_0000;

    // ==========================================================
    // Timer encodings
    localparam logic [3:0] MODE_NORMAL = 4'h0;
    localparam logic [3:0] MODE_PWM1 = 4'h2;
    localparam logic [3:0] MODE_PWM2 = 4'h3;
    localparam logic [1:0] IO_CAPTURE = 2'h2;
    localparam logic [1:0] IO_NO_OUT = 2'h0;
    localparam logic [2:0] CLR_BY_A = 3'h1;
    localparam logic [2:0] CLR_BY_B = 3'h2;
    localparam logic [2:0] CLR_BY_C = 3'h5;
    localparam logic [2:0] CLR_BY_D = 3'h6;
    localparam logic [2:0] PSC_EXT_A = 3'h4;
    localparam logic [2:0] PSC_EXT_B = 3'h5;
    localparam int NUM_TIMERS = 6;
    localparam int CLK_B_TIMERS = 3;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic [21:0] rsvd;
        logic dma1_end_out_en;
        logic dma0_end_out_en;
        logic pulse_out_11_en;
        logic pulse_out_10_en;
        logic pulse_out_9_en;
        logic pulse_out_8_en;
        logic pin3_dir;
        logic pin2_dir;
        logic pin1_dir;
        logic pin0_dir;
    } port_ctrl_t;

    typedef struct packed {
        logic [6:0] rsvd;
        logic buffer_mode_b;
        logic buffer_mode_a;
        logic [2:0] t0_counter_clear_src;
        logic [3:0] t0_chan_d_io_ctrl;
        logic [3:0] t0_chan_c_io_ctrl;
        logic [3:0] t0_chan_b_io_ctrl;
        logic [3:0] t0_chan_a_io_ctrl;
        logic [3:0] timer0_mode_field;
    } tmr_cfg_t;

    typedef struct packed {
        logic [11:0] rsvd;
        logic phase_ch5;
        logic phase_ch1;
        logic [5:0][2:0] timer_prescale_sel;
    } prescale_t;

    typedef enum logic [2:0] {
        SRC_INPUT = 3'b000,
        SRC_PORT = 3'b001,
        SRC_PULSE = 3'b010,
        SRC_TIMER = 3'b011,
        SRC_DMA = 3'b100
    } src_t;

endpackage

// ==== hdl/pin_source_select.sv ====
/*
 * Priority select for one pin: DMA end, timer, input, pulse, port.
 * Assumes all selects are stable register bits.
 */
`timescale 1ns/1ns
module pin_source_select import port1_mux_pkg::*; (
    // Selects
    input wire logic dma_en,
    input wire logic tmr_en,
    input wire logic dir,
    input wire logic pulse_en,
    // Source values
    input wire logic dma_val,
    input wire logic tmr_val,
    input wire logic pulse_val,
    input wire logic port_val,
    // Pin drive
    output logic pin_out,
    output logic pin_oe_n,
    output src_t src
);
    // ==========================================================
    // Fixed priority, highest first
    always_comb begin
        if (dma_en) begin
            src = SRC_DMA;
        end else if (tmr_en) begin
            src = SRC_TIMER;
        end else if (!dir) begin
            src = SRC_INPUT;
        end else if (pulse_en) begin
            src = SRC_PULSE;
        end else begin
            src = SRC_PORT;
        end
    end

    always_comb begin
        case (src)
            SRC_DMA: pin_out = dma_val;
            SRC_TIMER: pin_out = tmr_val;
            SRC_PULSE: pin_out = pulse_val;
            SRC_PORT: pin_out = port_val;
            default: pin_out = 1'b0;
        endcase
    end

    assign pin_oe_n = (src == SRC_INPUT);
endmodule

// ==== hdl/port1_low_pin_function_mux.sv ====
/*
 * Pin function mux for port pins 3..0 with its APB control registers.
 * Assumes the DMA, timer and pattern blocks supply output values and
 * take the routed inputs; pin inputs are synchronous to pclk.
 */
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ns
// What this block does
// [R1] Pin 3 drives DMA channel 1 end signal when its enable is set.
// [R2] Pin 3 next takes timer D output, then input, port or pulse 11.
// [R3] Pin 2: DMA 0 end first, timer C next, then input/port/pulse 10.
// [R4] Pin 1: timer B first, then input/port/pulse 9; always feeds DMA 1 request.
// [R5] Pin 0: timer A first, then input/port/pulse 8; always feeds DMA 0 request.
// [R6] Pin 3 feeds capture D in normal mode with capture I/O code.
// [R7] Pin 2 feeds capture C in normal mode with capture I/O code.
// [R8] Pin 1 feeds capture B in normal mode with capture I/O code.
// [R9] Pin 0 feeds capture A in normal mode with capture I/O code.
// [R10] Pin 3 is external clock B when timers 0..2 select it.
// [R11] Pin 3 clocks the phase counter when channel 1 or 5 counts phase.
// [R12] Pin 2 is external clock A when timers 0..5 select it.
// [R13] Pin 2 clocks the phase counter when channel 1 or 5 counts phase.
// [R14] PWM mode 1 with C output active suppresses timer D on pin 3.
// [R15] Buffer mode A or B disables PWM mode 1 output on pin 2.
// [R16] PWM mode 1 with A output active suppresses timer B on pin 1.
// [R17] Timer output setting decoded from mode, I/O code and clear source.
// [R18] Input routing ignores the output source selection; selection purely combinational.
module port1_low_pin_function_mux import port1_mux_pkg::*; (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Output sources
    input wire logic dma1_xfer_end,
    input wire logic dma0_xfer_end,
    input wire logic t0_chan_d_pin_out,
    input wire logic t0_chan_c_pin_out,
    input wire logic t0_chan_b_pin_out,
    input wire logic t0_chan_a_pin_out,
    input wire logic pulse_out_11,
    input wire logic pulse_out_10,
    input wire logic pulse_out_9,
    input wire logic pulse_out_8,
    input wire logic [3:0] port_data,
    // Pins
    input wire logic [3:0] pin_in,
    output logic [3:0] pin_out,
    output logic [3:0] pin_oe_n,
    // Routed inputs
    output logic t0_chan_d_pin_in,
    output logic t0_chan_c_pin_in,
    output logic t0_chan_b_pin_in,
    output logic t0_chan_a_pin_in,
    output logic [3:0] capture_en,
    output logic ext_timer_clk_a,
    output logic ext_timer_clk_b,
    output logic phase_clk_a,
    output logic phase_clk_b,
    output logic dma1_request,
    output logic dma0_request
);
    // ==========================================================
    // Registers
    port_ctrl_t ctrl_q;
    tmr_cfg_t cfg_q;
    prescale_t psc_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic setup;
    logic access;
    logic wr_en;
    logic hit;
    logic [31:0] status;
    logic [31:0] rd_mux;
    logic d_drive;
    logic c_drive;
    logic b_drive;
    logic a_drive;
    logic pwm1_a_on;
    logic pwm1_c_on;
    logic c_buffered;
    logic clk_a_sel;
    logic clk_b_sel;
    logic phase_on;
    src_t src3;
    src_t src2;
    src_t src1;
    src_t src0;

    assign setup = psel && !penable;
    assign access = psel && penable && pready_q;
    assign wr_en = access && pwrite && !pslverr_q;
    assign hit = (paddr == PORT_CTRL_OFF) || (paddr == TMR0_CFG_OFF)
        || (paddr == PRESCALE_OFF) || (paddr == STATUS_OFF);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= port_ctrl_t'(PORT_CTRL_RST);
        end else if (wr_en && paddr == PORT_CTRL_OFF) begin
            ctrl_q <= port_ctrl_t'({22'h000000, pwdata[9:0]});
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= tmr_cfg_t'(TMR0_CFG_RST);
        end else if (wr_en && paddr == TMR0_CFG_OFF) begin
            cfg_q <= tmr_cfg_t'({7'h00, pwdata[24:0]});
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            psc_q <= prescale_t'(PRESCALE_RST);
        end else if (wr_en && paddr == PRESCALE_OFF) begin
            psc_q <= prescale_t'({12'h000, pwdata[19:0]});
        end
    end

    // ==========================================================
    // APB answer: one wait-free access phase after setup
    always_comb begin
        case (paddr)
            PORT_CTRL_OFF: rd_mux = ctrl_q;
            TMR0_CFG_OFF: rd_mux = cfg_q;
            PRESCALE_OFF: rd_mux = psc_q;
            STATUS_OFF: rd_mux = status;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else if (setup) begin
            pready_q <= 1'b1;
            // Status is read-only; writing it is flagged
            pslverr_q <= !hit || (pwrite && paddr == STATUS_OFF);
            prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
    end

    assign pready = pready_q && psel && penable;
    assign pslverr = pslverr_q && pready;
    assign prdata = prdata_q;

    // ==========================================================
    // Timer channel 0 decode
    assign pwm1_c_on = (cfg_q.timer0_mode_field == MODE_PWM1)
        && (cfg_q.t0_chan_c_io_ctrl[1:0] != IO_NO_OUT);
    assign pwm1_a_on = (cfg_q.timer0_mode_field == MODE_PWM1)
        && (cfg_q.t0_chan_a_io_ctrl[1:0] != IO_NO_OUT);
    assign c_buffered = cfg_q.buffer_mode_a || cfg_q.buffer_mode_b; // [R15]

    // B and D never drive in PWM mode 1: their pair partner owns the pin
    timer_chan_decode #(.IS_AC(1'b0), .OWN_CLR(CLR_BY_D)) u_dec_d ( // [R14]
        .mode(cfg_q.timer0_mode_field),
        .io_ctrl(cfg_q.t0_chan_d_io_ctrl),
        .clr_src(cfg_q.t0_counter_clear_src),
        .pwm1_block(1'b0),
        .drive(d_drive),
        .capture(capture_en[3])
    );

    timer_chan_decode #(.IS_AC(1'b1), .OWN_CLR(CLR_BY_C)) u_dec_c (
        .mode(cfg_q.timer0_mode_field),
        .io_ctrl(cfg_q.t0_chan_c_io_ctrl),
        .clr_src(cfg_q.t0_counter_clear_src),
        .pwm1_block(c_buffered), // [R15]
        .drive(c_drive),
        .capture(capture_en[2])
    );

    timer_chan_decode #(.IS_AC(1'b0), .OWN_CLR(CLR_BY_B)) u_dec_b ( // [R16]
        .mode(cfg_q.timer0_mode_field),
        .io_ctrl(cfg_q.t0_chan_b_io_ctrl),
        .clr_src(cfg_q.t0_counter_clear_src),
        .pwm1_block(1'b0),
        .drive(b_drive),
        .capture(capture_en[1])
    );

    timer_chan_decode #(.IS_AC(1'b1), .OWN_CLR(CLR_BY_A)) u_dec_a (
        .mode(cfg_q.timer0_mode_field),
        .io_ctrl(cfg_q.t0_chan_a_io_ctrl),
        .clr_src(cfg_q.t0_counter_clear_src),
        .pwm1_block(1'b0),
        .drive(a_drive),
        .capture(capture_en[0])
    );

    // ==========================================================
    // Pin output selection
    pin_source_select u_pin3 ( // [R1] [R2]
        .dma_en(ctrl_q.dma1_end_out_en),
        .tmr_en(d_drive),
        .dir(ctrl_q.pin3_dir),
        .pulse_en(ctrl_q.pulse_out_11_en),
        .dma_val(dma1_xfer_end),
        .tmr_val(t0_chan_d_pin_out),
        .pulse_val(pulse_out_11),
        .port_val(port_data[3]),
        .pin_out(pin_out[3]),
        .pin_oe_n(pin_oe_n[3]),
        .src(src3)
    );

    pin_source_select u_pin2 ( // [R3]
        .dma_en(ctrl_q.dma0_end_out_en),
        .tmr_en(c_drive),
        .dir(ctrl_q.pin2_dir),
        .pulse_en(ctrl_q.pulse_out_10_en),
        .dma_val(dma0_xfer_end),
        .tmr_val(t0_chan_c_pin_out),
        .pulse_val(pulse_out_10),
        .port_val(port_data[2]),
        .pin_out(pin_out[2]),
        .pin_oe_n(pin_oe_n[2]),
        .src(src2)
    );

    pin_source_select u_pin1 ( // [R4]
        .dma_en(1'b0),
        .tmr_en(b_drive),
        .dir(ctrl_q.pin1_dir),
        .pulse_en(ctrl_q.pulse_out_9_en),
        .dma_val(1'b0),
        .tmr_val(t0_chan_b_pin_out),
        .pulse_val(pulse_out_9),
        .port_val(port_data[1]),
        .pin_out(pin_out[1]),
        .pin_oe_n(pin_oe_n[1]),
        .src(src1)
    );

    pin_source_select u_pin0 ( // [R5]
        .dma_en(1'b0),
        .tmr_en(a_drive),
        .dir(ctrl_q.pin0_dir),
        .pulse_en(ctrl_q.pulse_out_8_en),
        .dma_val(1'b0),
        .tmr_val(t0_chan_a_pin_out),
        .pulse_val(pulse_out_8),
        .port_val(port_data[0]),
        .pin_out(pin_out[0]),
        .pin_oe_n(pin_oe_n[0]),
        .src(src0)
    );

    // ==========================================================
    // Input routing, gated only by function enables
    always_comb begin
        clk_a_sel = 1'b0;
        clk_b_sel = 1'b0;
        for (int i = 0; i < NUM_TIMERS; i++) begin
            if (psc_q.timer_prescale_sel[i] == PSC_EXT_A) begin
                clk_a_sel = 1'b1; // [R12]
            end
            if (i < CLK_B_TIMERS && psc_q.timer_prescale_sel[i] == PSC_EXT_B) begin
                clk_b_sel = 1'b1; // [R10]
            end
        end
    end

    assign phase_on = psc_q.phase_ch1 || psc_q.phase_ch5;
    assign ext_timer_clk_a = clk_a_sel && pin_in[2]; // [R12]
    assign ext_timer_clk_b = clk_b_sel && pin_in[3]; // [R10]
    assign phase_clk_a = phase_on && pin_in[2]; // [R13]
    assign phase_clk_b = phase_on && pin_in[3]; // [R11]
    assign t0_chan_d_pin_in = capture_en[3] && pin_in[3]; // [R6]
    assign t0_chan_c_pin_in = capture_en[2] && pin_in[2]; // [R7]
    assign t0_chan_b_pin_in = capture_en[1] && pin_in[1]; // [R8]
    assign t0_chan_a_pin_in = capture_en[0] && pin_in[0]; // [R9]
    // Requests ignore the selected output source [R18]
    assign dma1_request = pin_in[1]; // [R4]
    assign dma0_request = pin_in[0]; // [R5]

    assign status = {13'h0000, phase_on, clk_b_sel, clk_a_sel,
        capture_en, src3 == SRC_TIMER, src2 == SRC_TIMER,
        src1 == SRC_TIMER, src0 == SRC_TIMER, pin_in,
        src3 == SRC_DMA, src2 == SRC_DMA, 2'b00};

    // ==========================================================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_dma1_end_wins: assert property ( // [R1]
        ctrl_q.dma1_end_out_en |-> pin_out[3] == dma1_xfer_end && !pin_oe_n[3])
        else $error("pin 3 not driving DMA end");
    a_pin3_timer_d: assert property ( // [R2]
        !ctrl_q.dma1_end_out_en && d_drive |-> pin_out[3] == t0_chan_d_pin_out
        && src3 == SRC_TIMER)
        else $error("pin 3 not driving timer D");
    a_pin3_port_in: assert property ( // [R2]
        !ctrl_q.dma1_end_out_en && !d_drive && !ctrl_q.pin3_dir |-> pin_oe_n[3])
        else $error("pin 3 not released");
    a_pin2_order: assert property ( // [R3]
        !ctrl_q.dma0_end_out_en && !c_drive && ctrl_q.pin2_dir
        && ctrl_q.pulse_out_10_en |-> pin_out[2] == pulse_out_10 && !pin_oe_n[2])
        else $error("pin 2 not driving pulse 10");
    a_pin1_port_out: assert property ( // [R4]
        !b_drive && ctrl_q.pin1_dir && !ctrl_q.pulse_out_9_en
        |-> pin_out[1] == port_data[1] && !pin_oe_n[1])
        else $error("pin 1 not driving port data");
    a_pin0_timer_a: assert property ( // [R5]
        a_drive |-> pin_out[0] == t0_chan_a_pin_out && dma0_request == pin_in[0])
        else $error("pin 0 timer or request wrong");
    a_capture_d_en: assert property ( // [R6]
        capture_en[3] == (cfg_q.timer0_mode_field == MODE_NORMAL
        && cfg_q.t0_chan_d_io_ctrl[3:2] == IO_CAPTURE))
        else $error("capture D enable wrong");
    a_capture_c_en: assert property ( // [R7]
        capture_en[2] |-> t0_chan_c_pin_in == pin_in[2])
        else $error("capture C not routed");
    a_capture_b_en: assert property ( // [R8]
        !capture_en[1] |-> !t0_chan_b_pin_in)
        else $error("capture B leaks");
    a_capture_a_en: assert property ( // [R9]
        capture_en[0] == (cfg_q.timer0_mode_field == MODE_NORMAL
        && cfg_q.t0_chan_a_io_ctrl[3:2] == IO_CAPTURE))
        else $error("capture A enable wrong");
    a_clk_b_route: assert property ( // [R10]
        psc_q.timer_prescale_sel[2] == PSC_EXT_B |-> ext_timer_clk_b == pin_in[3])
        else $error("clock B not routed");
    a_phase_b_route: assert property ( // [R11]
        psc_q.phase_ch5 |-> phase_clk_b == pin_in[3])
        else $error("phase clock B not routed");
    a_clk_a_route: assert property ( // [R12]
        psc_q.timer_prescale_sel[5] == PSC_EXT_A |-> ext_timer_clk_a == pin_in[2])
        else $error("clock A not routed");
    a_phase_a_route: assert property ( // [R13]
        psc_q.phase_ch1 |-> phase_clk_a == pin_in[2])
        else $error("phase clock A not routed");
    a_pwm1_d_off: assert property ( // [R14]
        pwm1_c_on |-> src3 != SRC_TIMER)
        else $error("timer D drives in PWM mode 1");
    a_buffer_c_off: assert property ( // [R15]
        pwm1_c_on && c_buffered |-> !c_drive)
        else $error("buffered PWM1 C still drives");
    a_pwm1_b_off: assert property ( // [R16]
        pwm1_a_on |-> !b_drive)
        else $error("timer B drives in PWM mode 1");
    a_cfg_takes_a: assert property ( // [R17]
        wr_en && paddr == TMR0_CFG_OFF && pwdata[7:0] == 8'h10
        |=> a_drive ##1 a_drive || $changed(cfg_q))
        else $error("compare A setting not taken");
    a_pwm2_own_clear: assert property ( // [R17]
        cfg_q.timer0_mode_field == MODE_PWM2
        && cfg_q.t0_counter_clear_src == CLR_BY_C |-> !c_drive)
        else $error("PWM2 C drives while clearing");
    a_apb_one_wait: assert property (
        setup ##1 psel && penable |-> pready)
        else $error("APB access not answered");

    c_dma_end: cover property (src3 == SRC_DMA ##1 src3 == SRC_TIMER);
    c_pwm1_pair: cover property (pwm1_a_on && pwm1_c_on && src0 == SRC_TIMER);
    c_pulse_out: cover property (src1 == SRC_PULSE ##1 src1 == SRC_PORT);
    c_capture_in: cover property (capture_en[0] && pin_in[0]);
endmodule

// ==== hdl/timer_chan_decode.sv ====
/*
 * Decodes one timer channel 0 pin: output (setting 1) and capture.
 * Assumes static configuration bits from the register file.
 */
`timescale 1ns/1ns
module timer_chan_decode import port1_mux_pkg::*; #(
    parameter bit IS_AC = 1'b0,
    parameter logic [2:0] OWN_CLR = 3'h0
) (
    // Configuration
    input wire logic [3:0] mode,
    input wire logic [3:0] io_ctrl,
    input wire logic [2:0] clr_src,
    input wire logic pwm1_block,
    // Decoded
    output logic drive,
    output logic capture
);
    // ==========================================================
    // Setting decode
    always_comb begin
        case (mode)
            MODE_NORMAL: drive = !io_ctrl[3] && (io_ctrl[1:0] != IO_NO_OUT); // [R17]
            MODE_PWM1: drive = IS_AC && (io_ctrl[1:0] != IO_NO_OUT) && !pwm1_block; // [R17]
            MODE_PWM2: drive = (io_ctrl[1:0] != IO_NO_OUT) && (clr_src != OWN_CLR); // [R17]
            default: drive = 1'b0;
        endcase
    end

    assign capture = (mode == MODE_NORMAL) && (io_ctrl[3:2] == IO_CAPTURE);
endmodule

// ==== testbench/port1_low_pin_function_mux_test.sv ====
/*
 * Self-checking bench for the low-nibble pin function mux.
 * Assumes the APB map and bit layout of the shared package.
 */
`timescale 1ns/1ns
module port1_low_pin_function_mux_test import port1_mux_pkg::*;;
    // ==========================================================
    // Signals
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rdat, port_sh, tmr_sh, psc_sh, st_sh;
    logic pready, pslverr, rerr, eca, ecb, pca, pcb, rq1, rq0;
    logic [3:0] pin_out, pin_oe_n, pin_wire, pin_ext, cap_in, capture_en;
    logic [13:0] src_vec;
    logic [31:0] masks [3] = '{32'h0000_03FF, 32'h01FF_FFFF, 32'h000F_FFFF};
    logic [2:0] own [4] = '{CLR_BY_A, CLR_BY_B, CLR_BY_C, CLR_BY_D};
    int err_count = 0;
    int checked = 0;
    int cycles = 0;

    always #10 pclk = ~pclk;

    // ==========================================================
    // Design and far side
    port1_sources_model src_u (.pclk(pclk), .presetn(presetn), .src_vec(src_vec),
        .pin_ext(pin_ext));
    // Released pins follow the outside world, driven pins their own value
    assign pin_wire = (pin_oe_n & pin_ext) | (~pin_oe_n & pin_out);

    port1_low_pin_function_mux dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .dma1_xfer_end(src_vec[13]), .dma0_xfer_end(src_vec[12]),
        .t0_chan_d_pin_out(src_vec[11]), .t0_chan_c_pin_out(src_vec[10]),
        .t0_chan_b_pin_out(src_vec[9]), .t0_chan_a_pin_out(src_vec[8]),
        .pulse_out_11(src_vec[7]), .pulse_out_10(src_vec[6]), .pulse_out_9(src_vec[5]),
        .pulse_out_8(src_vec[4]), .port_data(src_vec[3:0]), .pin_in(pin_wire),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .t0_chan_d_pin_in(cap_in[3]),
        .t0_chan_c_pin_in(cap_in[2]), .t0_chan_b_pin_in(cap_in[1]),
        .t0_chan_a_pin_in(cap_in[0]), .capture_en(capture_en), .ext_timer_clk_a(eca),
        .ext_timer_clk_b(ecb), .phase_clk_a(pca), .phase_clk_b(pcb),
        .dma1_request(rq1), .dma0_request(rq0));

    // ==========================================================
    // Tasks
    task automatic report_and_stop();
        if (err_count == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        chk("access cycles", 1, n);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic bit drv(int m, int io, int clr, int ow, bit ac, bit blk);
        if (m == MODE_NORMAL) return io[3] == 0 && io[1:0] != 0;
        if (m == MODE_PWM1) return ac && !blk && io[1:0] != 0;
        if (m == MODE_PWM2) return io[1:0] != 0 && clr != ow;
        return 0;
    endfunction

    task automatic check_pins();
        logic [3:0] eo, eoe, ec, tv, dv;
        logic dma, td, ca, cb, ph;
        int io;
        ca = 0;
        cb = 0;
        ph = psc_sh[18] | psc_sh[19];
        for (int k = 0; k < 6; k++) begin
            if (psc_sh[3 * k +: 3] == PSC_EXT_A) ca = 1;
            if (k < 3 && psc_sh[3 * k +: 3] == PSC_EXT_B) cb = 1;
        end
        for (int i = 0; i < 4; i++) begin
            io = (tmr_sh >> (4 + 4 * i)) & 15;
            td = drv(tmr_sh & 15, io, (tmr_sh >> 20) & 7, own[i], i % 2 == 0,
                i == 2 && tmr_sh[24:23] != 0);
            dma = i >= 2 && port_sh[6 + i];
            dv[i] = dma;
            tv[i] = td && !dma;
            ec[i] = tmr_sh[3:0] == MODE_NORMAL && io[3:2] == 2'b10;
            eoe[i] = !dma && !td && !port_sh[i];
            eo[i] = dma ? src_vec[10 + i] : td ? src_vec[8 + i] : !port_sh[i] ? 1'b0 :
                port_sh[4 + i] ? src_vec[4 + i] : src_vec[i];
        end
        // Pin levels in bits 7..4 can change on any cycle and are masked at the compare
        st_sh = {13'h0000, ph, cb, ca, ec, tv, 4'h0, dv[3:2], 2'b00};
        chk("pin_out", eo, pin_out);
        chk("pin_oe_n", eoe, pin_oe_n);
        chk("capture_en", ec, capture_en);
        chk("capture inputs", ec & pin_wire, cap_in);
        chk("clock a", {ca & pin_wire[2], ph & pin_wire[2]}, {eca, pca});
        chk("clock b", {cb & pin_wire[3], ph & pin_wire[3]}, {ecb, pcb});
        chk("dma requests", pin_wire[1:0], {rq1, rq0});
    endtask

    // ==========================================================
    // Hang guard
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 40000) begin
            err_count++;
            report_and_stop();
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        logic [31:0] w [3];
        void'($urandom(87));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        port_sh = PORT_CTRL_RST;
        tmr_sh = TMR0_CFG_RST;
        psc_sh = PRESCALE_RST;
        for (int r = 0; r < 3; r++) begin
            apb(1'b0, 12'(4 * r), 32'h0000_0000);
            chk("reset value", r == 0 ? PORT_CTRL_RST : r == 1 ? TMR0_CFG_RST : PRESCALE_RST, rdat);
        end
        @(negedge pclk);
        check_pins();
        apb(1'b0, 12'h010, 32'h0000_0000);
        chk("unmapped error", 1, rerr);
        chk("unmapped data", 0, rdat);
        apb(1'b1, STATUS_OFF, 32'hFFFF_FFFF);
        chk("status write error", 1, rerr);
        for (int t = 0; t < 300; t++) begin
            w[0] = $urandom;
            w[1] = $urandom;
            w[2] = $urandom;
            case ($urandom_range(0, 3))
                0: w[1][3:0] = MODE_NORMAL;
                1: w[1][3:0] = MODE_PWM1;
                2: w[1][3:0] = MODE_PWM2;
                default: w[1][3:0] = 4'($urandom);
            endcase
            for (int r = 0; r < 3; r++) begin
                apb(1'b1, 12'(4 * r), w[r]);
                chk("write error", 0, rerr);
            end
            port_sh = w[0] & masks[0];
            tmr_sh = w[1] & masks[1];
            psc_sh = w[2] & masks[2];
            apb(1'b0, 12'(4 * (t % 3)), 32'h0000_0000);
            chk("read back", w[t % 3] & masks[t % 3], rdat);
            repeat (6) begin
                @(negedge pclk);
                check_pins();
            end
            apb(1'b0, STATUS_OFF, 32'h0000_0000);
            chk("status", st_sh, rdat & 32'hFFFF_FF0F);
        end
        report_and_stop();
    end
endmodule

// ==== testbench/port1_sources_model.sv ====
/*
 * Far-side model: timer, DMA, pattern and port data sources plus the
 * external levels on the four pins.
 * Assumes the bench seeds the random generator and resolves pin levels.
 */
`timescale 1ns/1ns
module port1_sources_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Sources: [13:12] dma ends, [11:8] timer D..A, [7:4] pulse, [3:0] port
    output logic [13:0] src_vec,
    output logic [3:0] pin_ext
);
    // ==========================================================
    // Source activity
    // Skipped edges give both fast and slowly changing sources
    always @(posedge pclk) begin
        if (!presetn) begin
            src_vec <= 14'h0000;
            pin_ext <= 4'hF;
        end else if ($urandom_range(0, 3) != 0) begin
            src_vec <= 14'($urandom);
            pin_ext <= 4'($urandom);
        end
    end
endmodule
